// [logic/dor_regs.svh]
// Object addresses, field positions, reset values and timing counts of the output stage
`ifndef DOR_REGS_SVH
`define DOR_REGS_SVH

// Object indices and subindices
`define DOR_IDX_OUT_VALUE 16'h60fe
`define DOR_IDX_OUT_CTRL 16'h3250
`define DOR_IDX_OUT_ROUTE 16'h3252
`define DOR_SUB_OUT_VALUE 8'h01
`define DOR_SUB_CTRL_UNUSED 8'h01
`define DOR_SUB_CTRL_POL 8'h02
`define DOR_SUB_CTRL_MSEL 8'h03
`define DOR_SUB_CTRL_MVAL 8'h04
`define DOR_SUB_CTRL_COMPAT 8'h05
`define DOR_SUB_CTRL_ROUTE_EN 8'h08
`define DOR_SUB_ROUTE_FIRST 8'h01
`define DOR_SUB_ROUTE_LAST 8'h05

// Field positions
`define DOR_BIT_BRAKE 0
`define DOR_BIT_OUT1 16
`define DOR_BIT_ROUTE_EN 0

// Reset values
`define DOR_RST_WORD 32'h0000_0000
`define DOR_RST_ROUTE 16'h0100

// Source codes
`define DOR_SRC_ONE 8'h00
`define DOR_SRC_ZERO 8'h01
`define DOR_SRC_ENC_FIRST 8'h02
`define DOR_SRC_ENC_LAST 8'h08
`define DOR_SRC_POS_FIRST 8'h09
`define DOR_SRC_POS_LAST 8'h0f
`define DOR_SRC_PWM 8'h10
`define DOR_SRC_PWM_INV 8'h11

// Timing: half periods of the highest allowed output frequency
`define DOR_CLK_PERIOD_NS 50
`define DOR_HALF_FAST_NS 50000
`define DOR_HALF_PWM_NS 250000
`define DOR_HALF_SLOW_NS 1000000
`define DOR_HOLD_FAST ((`DOR_HALF_FAST_NS + `DOR_CLK_PERIOD_NS - 1) / `DOR_CLK_PERIOD_NS)
`define DOR_HOLD_PWM ((`DOR_HALF_PWM_NS + `DOR_CLK_PERIOD_NS - 1) / `DOR_CLK_PERIOD_NS)
`define DOR_HOLD_SLOW ((`DOR_HALF_SLOW_NS + `DOR_CLK_PERIOD_NS - 1) / `DOR_CLK_PERIOD_NS)

`endif

// [logic/dor_pkg.sv]
// Types shared by the digital output routing stage
package dor_pkg;

  typedef struct packed {
    logic [7:0] src;
    logic inv;
    logic [6:0] bit_sel;
  } dor_route_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } dor_obj_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } dor_obj_rsp_t;

endpackage : dor_pkg

// [logic/dor_output_routing.sv]
// Digital output stage: output word, polarity, manual override and output routing
//
// What this block does
// - Outputs 1 and up follow output word bits 16 and up.
// - Bits 0..15 are special; only bit 0 is used, for the brake output.
// - Polarity bit set drives the output low for a one in the word.
// - Manual select bit takes the level from the manual value, brake included.
// - Manual value bits act only while their manual select bit is set.
// - Control subentries one and five only store; no output effect.
// - Routing enable written one enters routing mode, zero leaves it.
// - In routing mode polarity, manual select and value have no effect.
// - Routing entries 1..5 serve PWM output and outputs 1 to 4.
// - Entry is 16 bits: high byte source, low byte gating bit.
// - Routed source is on when the selected word bit is one.
// - Entry bit 7 inverts the gating bit sense.
// - Source 00 holds one, source 01 holds zero.
// - Sources 02..08 give encoder pulses divided by 1 to 64.
// - Sources 09..0F give position pulses divided by 1 to 64.
// - Source 10 gives brake PWM, source 11 its inverse.
// - Rate limit in routing mode: 10 kHz outputs 1-2, 2 kHz PWM, 500 Hz others.
// - Automatic brake control drives word bit 0.
`include "dor_regs.svh"

module dor_output_routing #(
  parameter int NUM_OUT = 4,
  parameter int HOLD_FAST = `DOR_HOLD_FAST,
  parameter int HOLD_PWM = `DOR_HOLD_PWM,
  parameter int HOLD_SLOW = `DOR_HOLD_SLOW
) (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire dor_pkg::dor_obj_req_t obj_req, // Object access request
  output dor_pkg::dor_obj_rsp_t obj_rsp, // Object read answer
  input wire logic enc_pulse, // Encoder pulse signal
  input wire logic pos_pulse, // Actual position pulse signal
  input wire logic brake_pwm, // Brake PWM from brake timing
  input wire logic brake_ctl, // Automatic brake control bit
  output logic brake_o, // Brake pin drive value
  output logic brake_oe, // Brake pin pull-down enable
  output logic [NUM_OUT:0] out_o, // Pins: 0 PWM, 1..4 outputs
  output logic [NUM_OUT:0] out_oe, // Pin pull-down enables
  output logic routing_active // Routing mode status
);
  import dor_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (NUM_OUT < 1 || NUM_OUT > 4) begin : g_chk_num
    $error("NUM_OUT must be 1 to 4");
  end
  if (HOLD_FAST < 1 || HOLD_PWM < 1 || HOLD_SLOW < 1 ||
      HOLD_FAST > 65535 || HOLD_PWM > 65535 || HOLD_SLOW > 65535) begin : g_chk_hold
    $error("Hold counts must be 1 to 65535");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] word_q;
  logic [31:0] unused_q;
  logic [31:0] pol_q;
  logic [31:0] msel_q;
  logic [31:0] mval_q;
  logic [31:0] compat_q;
  logic route_en_q;
  dor_route_t route_q [NUM_OUT:0];

  function automatic logic hit(input dor_obj_req_t r, input logic [15:0] idx,
                               input logic [7:0] sub);
    hit = (r.index == idx) && (r.sub == sub);
  endfunction : hit

  logic wr_ctrl;
  assign wr_ctrl = obj_req.wr && (obj_req.index == `DOR_IDX_OUT_CTRL);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      word_q <= `DOR_RST_WORD;
    end else begin
      if (hit(obj_req, `DOR_IDX_OUT_VALUE, `DOR_SUB_OUT_VALUE) && obj_req.wr) begin
        word_q <= obj_req.wdata;
      end
      word_q[`DOR_BIT_BRAKE] <= brake_ctl;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unused_q <= `DOR_RST_WORD;
      pol_q <= `DOR_RST_WORD;
      msel_q <= `DOR_RST_WORD;
      mval_q <= `DOR_RST_WORD;
      compat_q <= `DOR_RST_WORD;
      route_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      case (obj_req.sub)
        `DOR_SUB_CTRL_UNUSED: unused_q <= obj_req.wdata;
        `DOR_SUB_CTRL_POL: pol_q <= obj_req.wdata;
        `DOR_SUB_CTRL_MSEL: msel_q <= obj_req.wdata;
        `DOR_SUB_CTRL_MVAL: mval_q <= obj_req.wdata;
        `DOR_SUB_CTRL_COMPAT: compat_q <= obj_req.wdata;
        `DOR_SUB_CTRL_ROUTE_EN: route_en_q <= obj_req.wdata[`DOR_BIT_ROUTE_EN];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Routing entries and read answer
  // ----------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi <= NUM_OUT; gi++) begin : g_route
    localparam logic [7:0] SUB = `DOR_SUB_ROUTE_FIRST + 8'(gi);
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        route_q[gi] <= `DOR_RST_ROUTE;
      end else if (obj_req.wr && hit(obj_req, `DOR_IDX_OUT_ROUTE, SUB)) begin
        route_q[gi] <= obj_req.wdata[15:0];
      end
    end
  end

  logic [31:0] rd_data;
  logic rd_ok;
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(obj_req, `DOR_IDX_OUT_VALUE, `DOR_SUB_OUT_VALUE)) begin
      rd_data = word_q;
    end else if (obj_req.index == `DOR_IDX_OUT_CTRL) begin
      case (obj_req.sub)
        `DOR_SUB_CTRL_UNUSED: rd_data = unused_q;
        `DOR_SUB_CTRL_POL: rd_data = pol_q;
        `DOR_SUB_CTRL_MSEL: rd_data = msel_q;
        `DOR_SUB_CTRL_MVAL: rd_data = mval_q;
        `DOR_SUB_CTRL_COMPAT: rd_data = compat_q;
        `DOR_SUB_CTRL_ROUTE_EN: rd_data = {31'h0000_0000, route_en_q};
        default: rd_ok = 1'b0;
      endcase
    end else if (obj_req.index == `DOR_IDX_OUT_ROUTE && obj_req.sub >= `DOR_SUB_ROUTE_FIRST &&
                 obj_req.sub <= `DOR_SUB_ROUTE_FIRST + 8'(NUM_OUT)) begin
      rd_data = {16'h0000, route_q[3'(obj_req.sub - `DOR_SUB_ROUTE_FIRST)]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      obj_rsp <= '0;
    end else begin
      obj_rsp.valid <= obj_req.rd;
      obj_rsp.err <= obj_req.rd && !rd_ok;
      obj_rsp.rdata <= (obj_req.rd && rd_ok) ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Pulse dividers
  // ----------------------------------------------------------------
  logic enc_d1_q;
  logic pos_d1_q;
  logic [5:0] enc_cnt_q;
  logic [5:0] pos_cnt_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enc_d1_q <= 1'b0;
      pos_d1_q <= 1'b0;
      enc_cnt_q <= 6'h00;
      pos_cnt_q <= 6'h00;
    end else begin
      enc_d1_q <= enc_pulse;
      pos_d1_q <= pos_pulse;
      if (enc_pulse && !enc_d1_q) enc_cnt_q <= enc_cnt_q + 6'h01;
      if (pos_pulse && !pos_d1_q) pos_cnt_q <= pos_cnt_q + 6'h01;
    end
  end

  logic [6:0] enc_div;
  logic [6:0] pos_div;
  assign enc_div = {enc_cnt_q, enc_pulse};
  assign pos_div = {pos_cnt_q, pos_pulse};

  function automatic logic src_level(input logic [7:0] src, input logic [6:0] ed,
                                     input logic [6:0] pd, input logic pwm);
    src_level = 1'b0;
    if (src == `DOR_SRC_ONE) src_level = 1'b1;
    else if (src == `DOR_SRC_ZERO) src_level = 1'b0;
    else if (src >= `DOR_SRC_ENC_FIRST && src <= `DOR_SRC_ENC_LAST)
      src_level = ed[3'(src - `DOR_SRC_ENC_FIRST)];
    else if (src >= `DOR_SRC_POS_FIRST && src <= `DOR_SRC_POS_LAST)
      src_level = pd[3'(src - `DOR_SRC_POS_FIRST)];
    else if (src == `DOR_SRC_PWM) src_level = pwm;
    else if (src == `DOR_SRC_PWM_INV) src_level = !pwm;
  endfunction : src_level

  // ----------------------------------------------------------------
  // Per-output level path
  // ----------------------------------------------------------------
  logic [NUM_OUT:0] gate;
  logic [NUM_OUT:0] raw;
  logic [NUM_OUT:0] lim_q;
  logic [NUM_OUT:0] level_q;
  logic [NUM_OUT:0] direct;
  logic brake_level_q;

  for (gi = 0; gi <= NUM_OUT; gi++) begin : g_out
    localparam int HOLD = (gi == 0) ? HOLD_PWM : (gi <= 2) ? HOLD_FAST : HOLD_SLOW;
    localparam int WB = `DOR_BIT_OUT1 + gi - 1;
    logic [15:0] hold_q;
    logic sel_bit;
    assign sel_bit = (route_q[gi].bit_sel < 7'd32) ? word_q[5'(route_q[gi].bit_sel)] : 1'b0;
    assign gate[gi] = sel_bit ^ route_q[gi].inv;
    assign raw[gi] = gate[gi] && src_level(route_q[gi].src, enc_div, pos_div, brake_pwm);
    if (gi == 0) begin : g_pwm
      assign direct[gi] = 1'b0;
    end else begin : g_plain
      assign direct[gi] = msel_q[WB] ? mval_q[WB] : (word_q[WB] ^ !pol_q[WB]) ^ 1'b1;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        hold_q <= 16'h0000;
        lim_q[gi] <= 1'b0;
      end else if (hold_q != 16'h0000) begin
        hold_q <= hold_q - 16'h0001;
      end else if (raw[gi] != lim_q[gi]) begin
        lim_q[gi] <= raw[gi];
        hold_q <= 16'(HOLD - 1);
      end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        level_q[gi] <= 1'b0;
      end else begin
        level_q[gi] <= route_en_q ? lim_q[gi] : direct[gi];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      brake_level_q <= 1'b0;
    end else if (!route_en_q && msel_q[`DOR_BIT_BRAKE]) begin
      brake_level_q <= mval_q[`DOR_BIT_BRAKE];
    end else if (!route_en_q) begin
      brake_level_q <= word_q[`DOR_BIT_BRAKE] ^ pol_q[`DOR_BIT_BRAKE];
    end else begin
      brake_level_q <= word_q[`DOR_BIT_BRAKE];
    end
  end

  // Open drain: low level pulls the pin, high level releases it
  assign out_o = '0;
  assign out_oe = ~level_q;
  assign brake_o = 1'b0;
  assign brake_oe = !brake_level_q;
  assign routing_active = route_en_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  localparam int LAST_WB = `DOR_BIT_OUT1 + NUM_OUT - 1;

  // ----------------------------------------------------------------
  // Plain mode checks
  // ----------------------------------------------------------------
  a_out1_word_bit: assert property (
      !route_en_q && !msel_q[16] |=>
      level_q[1] == ($past(word_q[16]) ^ $past(pol_q[16])))
    else $error("Output 1 does not follow word bit 16");
  a_last_word_bit: assert property (
      !route_en_q && !msel_q[LAST_WB] |=>
      level_q[NUM_OUT] == ($past(word_q[LAST_WB]) ^ $past(pol_q[LAST_WB])))
    else $error("Last output does not follow its word bit");
  a_out1_manual: assert property (
      !route_en_q && msel_q[16] |=> level_q[1] == $past(mval_q[16]))
    else $error("Output 1 ignores manual value");
  a_last_manual: assert property (
      !route_en_q && msel_q[LAST_WB] |=> level_q[NUM_OUT] == $past(mval_q[LAST_WB]))
    else $error("Last output ignores manual value");
  a_brake_manual: assert property (
      !route_en_q && msel_q[0] |=> brake_level_q == $past(mval_q[0]))
    else $error("Brake output ignores manual value");
  a_brake_polarity: assert property (
      !route_en_q && !msel_q[0] |=> brake_level_q == ($past(word_q[0]) ^ $past(pol_q[0])))
    else $error("Brake output does not follow word bit 0");
  a_brake_word: assert property (
      ##1 word_q[0] == $past(brake_ctl))
    else $error("Word bit 0 not driven by brake control");
  a_pwm_plain_low: assert property (
      !route_en_q |=> !level_q[0])
    else $error("PWM output not low outside routing");
  a_store_only: assert property (
      obj_req.wr && obj_req.index == `DOR_IDX_OUT_CTRL &&
      (obj_req.sub == `DOR_SUB_CTRL_UNUSED || obj_req.sub == `DOR_SUB_CTRL_COMPAT) |=>
      $stable(pol_q) && $stable(msel_q) && $stable(mval_q) && $stable(route_en_q))
    else $error("Store-only write changed a control");

  // ----------------------------------------------------------------
  // Routing mode checks
  // ----------------------------------------------------------------
  a_route_enable: assert property (
      wr_ctrl && obj_req.sub == `DOR_SUB_CTRL_ROUTE_EN |=>
      route_en_q == $past(obj_req.wdata[0]))
    else $error("Routing enable not taken");
  a_route_write: assert property (
      obj_req.wr && obj_req.index == `DOR_IDX_OUT_ROUTE &&
      obj_req.sub == `DOR_SUB_ROUTE_FIRST + 8'h01 |=> route_q[1] == $past(obj_req.wdata[15:0]))
    else $error("Output 1 routing entry not taken");
  a_routed_level: assert property (
      route_en_q |=> level_q[1] == $past(lim_q[1]))
    else $error("Routed output not from routing path");
  a_brake_routed: assert property (
      route_en_q |=> brake_level_q == $past(word_q[0]))
    else $error("Routed brake output not from word bit 0");
  a_gate_invert: assert property (
      route_q[1].bit_sel == 7'd5 |-> gate[1] == (word_q[5] ^ route_q[1].inv))
    else $error("Gating bit sense wrong");
  a_gate_off_low: assert property (
      !gate[1] && g_out[1].hold_q == 16'h0000 |=> !lim_q[1])
    else $error("Gated-off output not low");
  a_rate_hold: assert property (
      $changed(lim_q[1]) |=> $stable(lim_q[1])[*8])
    else $error("Output 1 toggles too fast");
  a_rate_pwm: assert property (
      $changed(lim_q[0]) |=> $stable(lim_q[0])[*8])
    else $error("PWM output toggles too fast");
  a_rate_last: assert property (
      $changed(lim_q[NUM_OUT]) |=> $stable(lim_q[NUM_OUT])[*8])
    else $error("Last output toggles too fast");

  // ----------------------------------------------------------------
  // Source checks
  // ----------------------------------------------------------------
  a_const_one: assert property (
      gate[1] && route_q[1].src == `DOR_SRC_ONE && g_out[1].hold_q == 16'h0000 |=> lim_q[1])
    else $error("Source 00 not one");
  a_const_zero: assert property (
      route_q[1].src == `DOR_SRC_ZERO |-> !raw[1])
    else $error("Source 01 not zero");
  a_enc_div1: assert property (
      gate[1] && route_q[1].src == `DOR_SRC_ENC_FIRST |-> raw[1] == enc_pulse)
    else $error("Encoder divide by 1 wrong");
  a_enc_div2: assert property (
      gate[1] && route_q[1].src == 8'h03 && $rose(enc_pulse) |=>
      raw[1] != $past(raw[1]) || !gate[1] || route_q[1].src != 8'h03)
    else $error("Encoder divide by 2 missed an edge");
  a_pos_div1: assert property (
      gate[1] && route_q[1].src == `DOR_SRC_POS_FIRST |-> raw[1] == pos_pulse)
    else $error("Position divide by 1 wrong");
  a_pos_div2: assert property (
      gate[1] && route_q[1].src == 8'h0a && $rose(pos_pulse) |=>
      raw[1] != $past(raw[1]) || !gate[1] || route_q[1].src != 8'h0a)
    else $error("Position divide by 2 missed an edge");
  a_pwm_direct: assert property (
      gate[2] && route_q[2].src == `DOR_SRC_PWM |-> raw[2] == brake_pwm)
    else $error("Brake PWM source wrong");
  a_pwm_inverse: assert property (
      gate[2] && route_q[2].src == `DOR_SRC_PWM_INV |-> raw[2] == !brake_pwm)
    else $error("Inverted brake PWM wrong");

  // ----------------------------------------------------------------
  // Scenario covers
  // ----------------------------------------------------------------
  c_routing_on: cover property (wr_ctrl && obj_req.sub == `DOR_SUB_CTRL_ROUTE_EN ##1 route_en_q);
  c_manual_brake: cover property (msel_q[0] && !route_en_q ##1 brake_level_q);
  c_routed_toggle: cover property (route_en_q && $changed(lim_q[1]));
  c_bad_read: cover property (obj_rsp.err);
  c_brake_routed: cover property (route_en_q && brake_level_q);

endmodule : dor_output_routing

// [sim/dor_load_model.sv]
// Open drain loads with pull-up resistors on every output pin
module dor_load_model (
  input wire logic brake_o, // Brake drive value
  input wire logic brake_oe, // Brake pull-down enable
  input wire logic [4:0] out_o, // Output drive values
  input wire logic [4:0] out_oe, // Output pull-down enables
  output logic brake_pin, // Brake pin level
  output logic [4:0] out_pin // Output pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven pin shows the drive value; a released pin floats up to the pull-up
  assign brake_pin = brake_oe ? brake_o : 1'b1;
  assign out_pin = (out_oe & out_o) | ~out_oe;
endmodule : dor_load_model

// [sim/digital_output_routing_test.sv]
// Self-checking bench for the digital output routing stage
`include "dor_regs.svh"

module digital_output_routing_test;
  import dor_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
  // ----------------------------------------
  // Signals and expectation helpers
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  dor_obj_req_t obj_req = '0;
  dor_obj_rsp_t obj_rsp;
  logic enc_pulse = 1'b0, pos_pulse = 1'b0, brake_pwm = 1'b0, brake_ctl = 1'b0;
  logic brake_o, brake_oe, routing_active, brake_pin, c, g, lvl;
  logic [4:0] out_o, out_oe, out_pin;
  logic [31:0] w, p, ms, mv, d, lv;
  logic [3:0] e;
  int bad_count = 0, n_compared = 0, cyc = 0, tg;
  logic [7:0] sb_ctl [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08};
  logic [7:0] srcs [7] = '{8'h00, 8'h01, 8'h02, 8'h09, 8'h10, 8'h11, 8'h12};
  logic [7:0] divs [5] = '{8'h03, 8'h0a, 8'h04, 8'h0b, 8'h05};
  int div_tg [5] = '{4, 4, 2, 2, 1};

  dor_output_routing #(.NUM_OUT(4), .HOLD_FAST(10), .HOLD_PWM(10), .HOLD_SLOW(10)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .obj_req(obj_req), .obj_rsp(obj_rsp),
    .enc_pulse(enc_pulse), .pos_pulse(pos_pulse), .brake_pwm(brake_pwm),
    .brake_ctl(brake_ctl), .brake_o(brake_o), .brake_oe(brake_oe), .out_o(out_o),
    .out_oe(out_oe), .routing_active(routing_active));
  dor_load_model loads (.brake_o(brake_o), .brake_oe(brake_oe), .out_o(out_o),
    .out_oe(out_oe), .brake_pin(brake_pin), .out_pin(out_pin));

  initial forever #25 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      close_out();
    end
  end

  function automatic logic [5:0] plain_exp(logic [31:0] w, p, ms, mv, logic c);
    logic [31:0] lv;
    lv = (ms & mv) | (~ms & ({w[31:1], c} ^ p));
    return {lv[0], lv[19:16], 1'b0};
  endfunction : plain_exp

  function automatic logic route_exp(logic [7:0] s, logic g, logic en, po, pw);
    if (!g) return 1'b0;
    case (s)
      8'h00: return 1'b1;
      8'h02: return en;
      8'h09: return po;
      8'h10: return pw;
      8'h11: return !pw;
      default: return 1'b0;
    endcase
  endfunction : route_exp

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] dt);
    @(posedge clk_sys);
    obj_req <= '{wr: 1'b1, rd: 1'b0, index: ix, sub: sb, wdata: dt};
    @(posedge clk_sys);
    obj_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] ix, input logic [7:0] sb, input logic [32:0] ex);
    @(posedge clk_sys);
    obj_req <= '{wr: 1'b0, rd: 1'b1, index: ix, sub: sb, wdata: 32'h0};
    @(posedge clk_sys);
    obj_req.rd <= 1'b0;
    #1;
    `CHK("read", {1'b1, ex}, {obj_rsp.valid, obj_rsp.err, obj_rsp.rdata})
  endtask : rd

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h349dd9c6));
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(16'h60fe, 8'h01, 33'h0);
    foreach (sb_ctl[i]) rd(16'h3250, sb_ctl[i], 33'h0);
    for (int s = 1; s <= 5; s++) rd(16'h3252, s[7:0], {17'h0, `DOR_RST_ROUTE});
    rd(16'h3250, 8'h06, {1'b1, 32'h0});
    `CHK("oe", 6'h3f, {brake_oe, out_oe})
    d = $urandom;
    wr(16'h3250, 8'h01, d);
    wr(16'h3250, 8'h05, ~d);
    rd(16'h3250, 8'h01, {1'b0, d});
    rd(16'h3250, 8'h05, {1'b0, ~d});
    tick(3);
    `CHK("pins", 6'h00, {brake_pin, out_pin})
    // Plain mode: word, polarity and manual override
    for (int i = 0; i < 20; i++) begin
      w = $urandom;
      p = $urandom;
      ms = (i == 0) ? 32'h0 : $urandom;
      mv = $urandom;
      c = $urandom;
      @(posedge clk_sys);
      brake_ctl <= c;
      wr(16'h60fe, 8'h01, w);
      wr(16'h3250, 8'h02, p);
      wr(16'h3250, 8'h03, ms);
      wr(16'h3250, 8'h04, mv);
      tick(3);
      `CHK("pins", plain_exp(w, p, ms, mv, c), {brake_pin, out_pin})
    end
    rd(16'h60fe, 8'h01, {1'b0, w[31:1], c});
    wr(16'h3252, 8'h02, 32'hffff_0405);
    rd(16'h3252, 8'h02, {17'h0, 16'h0405});
    // Routing mode: sources 00, 01, 02, 09, 10, 11 and unused 12 on every output
    wr(16'h3250, 8'h08, 32'h1);
    tick(1);
    `CHK("mode", 1'b1, routing_active)
    foreach (srcs[j]) for (int k = 0; k <= 4; k++) begin
      w = $urandom;
      e = $urandom;
      d = $urandom;
      @(posedge clk_sys);
      {brake_ctl, brake_pwm, pos_pulse, enc_pulse} <= e;
      wr(16'h3252, 8'(k + 1), {16'h0, srcs[j], d[7], 2'b00, d[4:0]});
      wr(16'h60fe, 8'h01, w);
      for (int s = 2; s <= 4; s++) wr(16'h3250, s[7:0], $urandom);
      tick(15);
      lv = {w[31:1], e[3]};
      g = lv[d[4:0]] ^ d[7];
      `CHK("route", route_exp(srcs[j], g, e[0], e[1], e[2]), out_pin[k])
      `CHK("brake", e[3], brake_pin)
    end
    // Divided pulse sources on output 1
    @(posedge clk_sys);
    {brake_ctl, brake_pwm, pos_pulse, enc_pulse} <= 4'h0;
    wr(16'h60fe, 8'h01, 32'h0001_0000);
    foreach (divs[j]) begin
      wr(16'h3252, 8'h02, {16'h0, divs[j], 8'h10});
      tick(15);
      lvl = out_pin[1];
      tg = 0;
      for (int n = 0; n < 4; n++) begin
        @(posedge clk_sys);
        {pos_pulse, enc_pulse} <= 2'b11;
        tick(20);
        if (out_pin[1] !== lvl) tg++;
        lvl = out_pin[1];
        @(posedge clk_sys);
        {pos_pulse, enc_pulse} <= 2'b00;
        tick(20);
      end
      `CHK("div", div_tg[j], tg)
    end
    wr(16'h3250, 8'h02, 32'h0001_0001);
    wr(16'h3250, 8'h03, 32'h0);
    wr(16'h3250, 8'h08, 32'h0);
    tick(3);
    `CHK("mode", 1'b0, routing_active)
    `CHK("pins", plain_exp(32'h1_0000, 32'h1_0001, 0, 0, 0), {brake_pin, out_pin})
    close_out();
  end
endmodule : digital_output_routing_test
